// ===== include/rxcmd_defs.svh
// Bit positions and codes for the receive-command status byte.
// Assumes inclusion by bare name from design files.
`ifndef RXCMD_DEFS_SVH
`define RXCMD_DEFS_SVH
`define LS_LSB 0
`define VBUS_LSB 2
`define EVT_LSB 4
`define ID_BIT 6
`define ALT_BIT 7
`define XCVR_HS 2'h0
`define XCVR_FS 2'h1
`define XCVR_LS 2'h2
`define XCVR_FS4LS 2'h3
`define OPMODE_CHIRP 2'h2
`define LS_SE0 2'h0
`define LS_J 2'h1
`define LS_K 2'h2
`define LS_SE1 2'h3
`endif

// ===== include/rxcmd_pkg.sv
// Types shared by the receive-command encoder.
// Assumes nothing of its surroundings.
package rxcmd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1,
    ST_HOLD = 2'h3
  } send_state_t;
endpackage

// ===== src/rxcmd_status_encoder.sv
// Receive-command status byte builder and sender toward the link.
// Assumes all inputs synchronous to sys_clk; the link accepts a byte at any time.
`timescale 1ns/10ps
`include "rxcmd_defs.svh"

module rxcmd_status_encoder (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic dp_level,
  input wire logic dm_level,
  input wire logic squelch,
  input wire logic hs_diff_rx_level,
  input wire logic [1:0] xcvr_select,
  input wire logic term_select,
  input wire logic [1:0] op_mode,
  input wire logic dp_pulldown,
  input wire logic dm_pulldown,
  input wire logic [1:0] vbus_state,
  input wire logic [1:0] rx_event,
  input wire logic id_pin,
  input wire logic bvalid,
  input wire logic bvalid_rise_en,
  input wire logic bvalid_fall_en,
  output logic dir,
  output logic [7:0] rxcmd_data,
  output logic rxcmd_strobe
);

  // Maps raw line levels to the two-bit line state per mode and role
  function automatic logic [1:0] encode_ls(input logic dp, input logic dm, input logic sq,
                                           input logic hsrx, input logic [1:0] xs,
                                           input logic ts, input logic [1:0] om,
                                           input logic host);
    logic [1:0] fs;
    fs = {dm, dp};
    encode_ls = fs;
    if (xs == `XCVR_HS && !ts && om == `OPMODE_CHIRP) begin
      encode_ls = sq ? 2'h0 : (hsrx ? 2'h1 : 2'h2);
    end else if (xs == `XCVR_HS && !ts) begin
      encode_ls = sq ? 2'h0 : 2'h1;
    end else if (host && xs == `XCVR_LS && ts) begin
      encode_ls = fs; // Raw levels: dp high is K, dm high is J
    end
  endfunction

  logic [1:0] line_state;
  logic [6:0] status_now;
  logic [6:0] last_sent_ff;
  logic [6:0] nxt_last_sent;
  logic bvalid_ff;
  logic nxt_bvalid;
  logic alt_pend_ff;
  logic nxt_alt_pend;
  logic dir_ff;
  logic nxt_dir;
  logic strobe_ff;
  logic nxt_strobe;
  logic [7:0] data_ff;
  logic [7:0] nxt_data;
  logic alt_event;
  logic changed;
  rxcmd_pkg::send_state_t state_ff;
  rxcmd_pkg::send_state_t nxt_state;

  // Live status fields assembled each cycle
  always_comb begin
    line_state = encode_ls(dp_level, dm_level, squelch, hs_diff_rx_level, xcvr_select,
                           term_select, op_mode, dp_pulldown & dm_pulldown);
    status_now = {id_pin, rx_event, vbus_state, line_state};
    alt_event = (bvalid & ~bvalid_ff & bvalid_rise_en) |
                (~bvalid & bvalid_ff & bvalid_fall_en);
    changed = (status_now != last_sent_ff) | alt_event | alt_pend_ff;
  end

  // Sender: one byte per change, all current fields merged
  always_comb begin
    nxt_state = state_ff;
    nxt_last_sent = last_sent_ff;
    nxt_bvalid = bvalid;
    nxt_alt_pend = alt_pend_ff | alt_event;
    nxt_dir = 1'b0;
    nxt_strobe = 1'b0;
    nxt_data = data_ff;
    unique case (state_ff)
      rxcmd_pkg::ST_IDLE: begin
        if (changed) begin
          nxt_state = rxcmd_pkg::ST_SEND;
          nxt_dir = 1'b1;
        end
      end
      rxcmd_pkg::ST_SEND: begin
        nxt_dir = 1'b1;
        nxt_strobe = 1'b1;
        nxt_data = {alt_pend_ff | alt_event, status_now};
        nxt_last_sent = status_now;
        nxt_alt_pend = 1'b0;
        nxt_state = rxcmd_pkg::ST_HOLD;
      end
      rxcmd_pkg::ST_HOLD: begin
        if (changed) begin
          nxt_dir = 1'b1; // Back-to-back byte without turnaround
          nxt_state = rxcmd_pkg::ST_SEND;
        end else begin
          nxt_state = rxcmd_pkg::ST_IDLE;
        end
      end
      default: nxt_state = rxcmd_pkg::ST_IDLE;
    endcase
  end

  // Registers for the sender
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= rxcmd_pkg::ST_IDLE;
      last_sent_ff <= 7'h00;
      bvalid_ff <= 1'b0;
      alt_pend_ff <= 1'b0;
      dir_ff <= 1'b0;
      strobe_ff <= 1'b0;
      data_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      last_sent_ff <= nxt_last_sent;
      bvalid_ff <= nxt_bvalid;
      alt_pend_ff <= nxt_alt_pend;
      dir_ff <= nxt_dir;
      strobe_ff <= nxt_strobe;
      data_ff <= nxt_data;
    end
  end

  assign dir = dir_ff;
  assign rxcmd_data = data_ff;
  assign rxcmd_strobe = strobe_ff;

  sequence change_seen_s;
    changed && state_ff == rxcmd_pkg::ST_IDLE;
  endsequence

  // A change from idle yields a byte two cycles later
  change_send_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    change_seen_s |-> ##2 rxcmd_strobe) else $error("no byte after change");
  // Strobe only while dir is high
  strobe_dir_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rxcmd_strobe |-> dir) else $error("strobe without dir");
  // Sent byte carries the fields seen one cycle before
  fields_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rxcmd_strobe |-> rxcmd_data[6:0] == $past(status_now)) else $error("field mismatch");
  // Enabled B-valid rise gives bit 7 within four cycles
  alt_rise_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (bvalid_rise_en && bvalid && !bvalid_ff) |-> ##[1:4] (rxcmd_strobe && rxcmd_data[7]))
    else $error("alt bit missing");
  // Chirp encoding with squelch gives zero
  chirp_sq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (xcvr_select == 2'h0 && !term_select && op_mode == 2'h2 && squelch) |-> line_state == 2'h0)
    else $error("chirp squelch code");
  // Host low-speed K (dp high) maps to 01
  host_ls_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dp_pulldown && dm_pulldown && xcvr_select == 2'h2 && term_select && dp_level && !dm_level)
    |-> line_state == 2'h1) else $error("low-speed K code");
  // Peripheral full-speed passes line levels
  periph_fs_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!dp_pulldown && xcvr_select == 2'h1) |-> line_state == {dm_level, dp_level})
    else $error("full-speed code");
  // ID bit follows pin in sent byte
  id_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rxcmd_strobe |-> rxcmd_data[6] == $past(id_pin)) else $error("id bit wrong");

  // Request phase: dir up one cycle, then the strobe
  sequence dir_then_byte_s;
    !rxcmd_strobe ##1 rxcmd_strobe;
  endsequence

  // One-cycle strobe pulse
  sequence byte_pulse_s;
    rxcmd_strobe ##1 !rxcmd_strobe;
  endsequence

  // Strobe lasts exactly one cycle, so bytes stand apart
  strobe_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rxcmd_strobe
    |=> !rxcmd_strobe)
    else $error("strobe longer than one cycle");

  // Rising dir is followed by the byte one cycle later
  dir_lead_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(dir)
    |-> dir_then_byte_s)
    else $error("dir rose without byte");

  // Changes seen together leave as one single byte
  merge_once_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    change_seen_s
    |-> ##2 byte_pulse_s)
    else $error("merged change not one byte");

  // Data holds between strobes
  data_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rxcmd_strobe
    |-> $stable(rxcmd_data))
    else $error("data moved without strobe");

  // Line-state bits of the byte follow the encoded lines
  ls_field_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rxcmd_strobe
    |-> rxcmd_data[1:0] == $past(line_state))
    else $error("line state field wrong");

  // VBUS bits of the byte
  vbus_field_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rxcmd_strobe
    |-> rxcmd_data[3:2] == $past(vbus_state))
    else $error("vbus field wrong");

  // Receive-event bits of the byte
  evt_field_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rxcmd_strobe
    |-> rxcmd_data[5:4] == $past(rx_event))
    else $error("event field wrong");

  // High-speed outside chirp: squelch 00, else 01
  hs_squelch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (xcvr_select == 2'h0 && !term_select && op_mode != 2'h2)
    |-> line_state == (squelch ? 2'h0 : 2'h1))
    else $error("high-speed code");

  // Chirp unsquelched follows the high-speed receiver level
  chirp_rx_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (xcvr_select == 2'h0 && !term_select && op_mode == 2'h2 && !squelch)
    |-> line_state == (hs_diff_rx_level ? 2'h1 : 2'h2))
    else $error("chirp receiver code");

  // Host full-speed passes line levels
  host_fs_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dp_pulldown && dm_pulldown && xcvr_select[0] && term_select)
    |-> line_state == {dm_level, dp_level})
    else $error("host full-speed code");

  // Host low-speed J (dm high) maps to 10
  host_ls_j_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dp_pulldown && dm_pulldown && xcvr_select == 2'h2 && term_select && !dp_level && dm_level)
    |-> line_state == 2'h2)
    else $error("low-speed J code");

  // Enabled B-valid fall gives bit 7 within four cycles
  alt_fall_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (bvalid_fall_en && !bvalid && bvalid_ff)
    |-> ##[1:4] (rxcmd_strobe && rxcmd_data[7]))
    else $error("alt bit missing on fall");

  // Bit 7 only when an enabled edge was seen
  alt_cause_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rxcmd_strobe && rxcmd_data[7])
    |-> $past(alt_pend_ff | alt_event))
    else $error("alt bit without edge");

  // No change from idle keeps dir low
  quiet_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_ff == rxcmd_pkg::ST_IDLE && !changed)
    |=> !dir)
    else $error("dir without change");

  // A change during the strobe keeps dir high for the next byte
  back_to_back_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rxcmd_strobe && changed)
    |=> dir)
    else $error("back-to-back dir dropped");

  // Without a new change dir drops after the strobe
  dir_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rxcmd_strobe && !changed)
    |=> !dir)
    else $error("dir held after byte");

  // Reset clears every output
  reset_out_a: assert property (@(posedge sys_clk)
    sys_rst
    |=> (!dir && !rxcmd_strobe && rxcmd_data == 8'h00))
    else $error("outputs not cleared by reset");

endmodule

// ===== bench/link_rxcmd_sink.sv
// Link-side model that takes every receive-command byte offered.
// Assumes the bytes arrive on sys_clk with a one-cycle strobe.
`timescale 1ns/10ps
module link_rxcmd_sink (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic dir,
  input wire logic [7:0] rxcmd_data,
  input wire logic rxcmd_strobe,
  output logic [7:0] last_byte,
  output int byte_count
);
  // Accepts single and back-to-back bytes with no stall
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      byte_count <= 0;
      last_byte <= 8'h00;
    end else if (rxcmd_strobe && dir) begin
      byte_count <= byte_count + 1;
      last_byte <= rxcmd_data;
    end
  end
endmodule

// ===== bench/ulpi_rxcmd_status_encoder_tb.sv
// Random and corner checks of the receive-command byte encoder.
// Assumes the encoder from src/ and the link model from bench/.
`timescale 1ns/10ps
module ulpi_rxcmd_status_encoder_tb;
  logic sys_clk = 0, sys_rst = 1, dp = 0, dm = 0, sq = 0, hsrx = 0, ts = 0;
  logic dpp = 0, dmp = 0, id = 0, bv = 0, bre = 0, bfe = 0, dir, stb, got;
  logic [1:0] xs = 2'h0, om = 2'h0, vb = 2'h0, ev = 2'h0;
  logic [7:0] data, last;
  logic [31:0] rng = 32'h0000_0033;
  int fails = 0, check_count = 0, cyc = 0, cnt, base;
  rxcmd_status_encoder dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .dp_level(dp),
    .dm_level(dm), .squelch(sq), .hs_diff_rx_level(hsrx), .xcvr_select(xs),
    .term_select(ts), .op_mode(om), .dp_pulldown(dpp), .dm_pulldown(dmp),
    .vbus_state(vb), .rx_event(ev), .id_pin(id), .bvalid(bv), .bvalid_rise_en(bre),
    .bvalid_fall_en(bfe), .dir(dir), .rxcmd_data(data), .rxcmd_strobe(stb));
  link_rxcmd_sink link_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .dir(dir),
    .rxcmd_data(data), .rxcmd_strobe(stb), .last_byte(last), .byte_count(cnt));
  // Clock and cycle ceiling
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] nxt(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // Expected line state from mode, squelch and line levels
  function automatic logic [1:0] exp_ls();
    if (xs == 2'h0) return sq ? 2'h0 : ((om == 2'h2) ? (hsrx ? 2'h1 : 2'h2) : 2'h1);
    return {dm, dp}; // Host low-speed too: dp high is K (01), dm high is J (10)
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits a bounded time for a strobe
  task automatic await();
    got = 0;
    repeat (6) begin
      @(posedge sys_clk);
      #1;
      if (stb === 1'b1 && !got) begin
        got = 1;
        chk(data, {bre & bv | bfe & ~bv, id, ev, vb, exp_ls()});
      end
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Random status changes, then bvalid edges under each enable pair
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 0;
    for (int i = 0; i < 60; i++) begin
      @(negedge sys_clk);
      rng = nxt(rng);
      {dp, dm, sq, hsrx, vb, ev, om, xs} = rng[11:0];
      {dpp, dmp} = {2{rng[12]}};
      ts = (xs != 2'h0);
      id = ~id;
      base = cnt;
      await();
      chk({7'h00, got}, 8'h01);
      chk({7'h00, dir}, 8'h00);
      chk(8'(cnt - base), 8'h01);
    end
    for (int k = 0; k < 8; k++) begin
      @(negedge sys_clk);
      {bre, bfe} = k[1:0];
      bv = ~bv;
      base = cnt;
      await();
      chk({7'h00, got}, {7'h00, bre & bv | bfe & ~bv});
      @(negedge sys_clk);
      bre = 0;
      bfe = 0;
    end
    report_and_stop();
  end
endmodule
